// [hdl/sbt_pkg.sv]
// Package of constants, types and timing counts for the sideband timing block
package sbt_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned CLK_NS = 40;
	// Interval figures in their own units
	localparam int unsigned DESEL_HIZ_US = 200;
	localparam int unsigned WARMUP_CLKS = 2;
	localparam int unsigned POWERUP_S = 2;
	localparam int unsigned EXEC_MS = 50;
	localparam int unsigned ARST_S = 2;
	localparam int unsigned SRST_S = 2;
	localparam int unsigned TOKEN_TMO_CLKS = 32000;
	localparam int unsigned OPCODE_MAX_CLKS = 32;
	localparam int unsigned BYPASS_MAX_CLKS = 32;
	localparam int unsigned TOKEN_RXD_MAX_CLKS = 32;
	localparam int unsigned PAUSE_RENEW_CLKS = 50331648;
	localparam int unsigned PAUSE_TIMER_CYCLES = 3;
	localparam int unsigned IPG_OVERLAP_CLKS = 6;
	// Derived cycle counts; microsecond and millisecond times round down
	localparam longint unsigned DESEL_HIZ_CYC = longint'(DESEL_HIZ_US) * CLK_HZ / 1000000;
	localparam longint unsigned POWERUP_CYC = longint'(POWERUP_S) * CLK_HZ;
	localparam longint unsigned EXEC_CYC = longint'(EXEC_MS) * CLK_HZ / 1000;
	localparam longint unsigned ARST_CYC = longint'(ARST_S) * CLK_HZ;
	localparam longint unsigned SRST_CYC = longint'(SRST_S) * CLK_HZ;
	localparam int unsigned CNT_W = 32;
	localparam int unsigned DATA_W = 2;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic [31:0] CNT_ZERO = 32'h0;
	localparam logic [31:0] CNT_ONE = 32'h1;
	// Transmit-side state of the package
	typedef enum logic [2:0] {
		SBT_ST_QUIET,
		SBT_ST_WAIT_TOKEN,
		SBT_ST_WARMUP,
		SBT_ST_SEND,
		SBT_ST_DRAIN
	} sbt_state_e;
	// Receive-data lane bundle toward the management controller
	typedef struct packed {
		logic [1:0] rxd;
		logic crs_dv;
		logic rx_er;
	} sbt_rx_s;
	// One entry of the data FIFO
	typedef struct packed {
		logic [1:0] dibit;
		logic last;
	} sbt_word_s;
	localparam int unsigned WORD_W = $bits(sbt_word_s);
endpackage

// [hdl/sbt_sync.sv]
// Three-stage synchroniser for pin inputs with agreement filter
`timescale 1ns/10ps
module sbt_sync #(
	parameter int unsigned W = 1
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);
	import sbt_pkg::*;
	logic [W-1:0] s1_reg; // First stage, read only by stage two
	logic [W-1:0] s2_reg; // Second stage
	logic [W-1:0] s3_reg; // Third stage
	logic [W-1:0] level_reg; // Filtered level
	// Shift chain
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// Accept a change once stages two and three agree, per bit
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			always_ff @(posedge mclk_i) begin
				if (reset_i) begin
					level_reg[gi] <= 1'b0;
				end else if (s2_reg[gi] == s3_reg[gi]) begin
					level_reg[gi] <= s3_reg[gi];
				end
			end
		end
	endgenerate
	assign level_o = level_reg;
endmodule

// [hdl/sbt_fifo.sv]
// Parameterised valid/ready FIFO for receive data words
`timescale 1ns/10ps
module sbt_fifo #(
	parameter int unsigned WIDTH = 3,
	parameter int unsigned DEPTH = 16
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	import sbt_pkg::*;
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage array
	logic [AW-1:0] wr_reg; // Write pointer
	logic [AW-1:0] rd_reg; // Read pointer
	logic [AW:0] cnt_reg; // Fill level
	logic push; // Word accepted
	logic pop; // Word delivered
	assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_reg];
	// Storage write
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem[wr_reg] <= in_data_i;
		end
	end
	// Pointers wrap at depth
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			end
		end
	end
	// Fill level
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cnt_reg <= '0;
		end else if (push && !pop) begin
			cnt_reg <= cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule

// [hdl/sbt_timing.sv]
// Sideband package timing enforcement: drivers, arbitration ring, deadlines
`timescale 1ns/10ps
module sbt_timing #(
	parameter longint unsigned DESEL_CYC = sbt_pkg::DESEL_HIZ_CYC,
	parameter longint unsigned POWER_CYC = sbt_pkg::POWERUP_CYC,
	parameter longint unsigned EXEC_LIM_CYC = sbt_pkg::EXEC_CYC,
	parameter longint unsigned ARST_LIM_CYC = sbt_pkg::ARST_CYC,
	parameter longint unsigned SRST_LIM_CYC = sbt_pkg::SRST_CYC,
	parameter longint unsigned TOKEN_TMO = sbt_pkg::TOKEN_TMO_CLKS,
	parameter longint unsigned PAUSE_LIM = sbt_pkg::PAUSE_RENEW_CLKS,
	parameter int unsigned DEPTH = sbt_pkg::FIFO_DEPTH
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic select_i,
	input wire logic deselect_done_i,
	input wire logic cmd_done_i,
	input wire logic resp_start_i,
	input wire logic async_reset_evt_i,
	input wire logic reset_resp_done_i,
	input wire logic hw_arb_i,
	input wire logic bypass_i,
	input wire logic token_req_i,
	input wire logic ipg_left_i,
	input wire logic pause_req_i,
	input wire logic data_valid_i,
	input wire logic [1:0] data_i,
	input wire logic data_last_i,
	output logic data_ready_o,
	input wire logic arbitration_ring_input,
	output logic arbitration_ring_output,
	output sbt_pkg::sbt_rx_s rx_o,
	output logic rx_oe_o,
	output logic ready_o,
	output logic resp_late_o,
	output logic token_timeout_o,
	output logic pause_allowed_o
);
	import sbt_pkg::*;

	// Interval counters clear at their own starting edge; the warm-up counter clears only when the token arrives
	sbt_state_e state_reg; // Transmit state
	logic [CNT_W-1:0] desel_cnt_reg; // Deselect to float counter
	logic desel_pend_reg; // Float pending after deselect
	logic [CNT_W-1:0] warm_cnt_reg; // Driver warm-up counter
	logic [CNT_W-1:0] tok_cnt_reg; // Token wait counter
	logic [CNT_W-1:0] deaf_cnt_reg; // Power-up and reset deafness counter
	logic [CNT_W-1:0] exec_cnt_reg; // Command execution counter
	logic exec_run_reg; // Command awaiting its response
	logic [CNT_W-1:0] pause_cnt_reg; // Pause renewal window counter
	logic pause_run_reg; // Pause condition active
	logic ring_out_reg; // Ring output flop
	logic ring_in; // Synchronised ring input
	logic oe_reg; // Driver enable
	sbt_rx_s rx_reg; // Registered lane outputs
	logic ready_reg; // Able to answer commands
	logic late_reg; // Response deadline missed
	logic tmo_reg; // Token timeout flag
	logic pause_ok_reg; // Renewal permitted
	// Buffer and ring helpers
	sbt_word_s fifo_in; // FIFO write word
	sbt_word_s fifo_out; // FIFO read word
	logic fifo_valid; // FIFO holds a word
	logic fifo_pop; // Word taken onto the lanes
	logic token_seen; // Token op-code arrived
	logic token_early; // Token may start inside the gap
	localparam int unsigned FILL_W = $clog2(DEPTH) + 1;
	logic [FILL_W-1:0] fill_reg; // Words held, mirrored from pushes and pops
	logic [FILL_W-1:0] fill_next; // Fill level after this edge
	logic room_reg; // Registered ready toward the data source
	logic fifo_ready; // Buffer's own ready
	logic take; // Word accepted this edge

	// Ring input arrives from a peer package.
	// It runs off another package's timing, so it takes three flops and a
	// change counts only once the last two agree.
	sbt_sync #(.W(1)) u_sync (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.pin_i(arbitration_ring_input),
		.level_o(ring_in)
	);

	// Packet data buffer; the source is stalled by the registered ready
	// below, which mirrors the buffer's fill level.
	assign fifo_in = '{dibit: data_i, last: data_last_i};
	sbt_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.in_valid_i(take),
		.in_ready_o(fifo_ready),
		.in_data_i(fifo_in),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out)
	);

	// Source sees a registered ready, so the fill level is tracked here as well;
	// ready drops at the edge that takes the last free slot, never one late
	assign take = data_valid_i && room_reg && fifo_ready;
	// Next fill level from this edge's push and pop
	always_comb begin
		fill_next = fill_reg;
		if (take && !fifo_pop) begin
			fill_next = fill_reg + 1'b1;
		end else if (fifo_pop && !take) begin
			fill_next = fill_reg - 1'b1;
		end
	end
	// Fill level and ready flop; ready is low while in reset
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			fill_reg <= '0;
			room_reg <= 1'b0;
		end else begin
			fill_reg <= fill_next;
			room_reg <= (fill_next != FILL_W'(DEPTH));
		end
	end

	// Token op-code seen as a high ring bit while waiting
	assign token_seen = ring_in;
	// Token launch allowed once the gap has at most six clocks left
	assign token_early = ipg_left_i && (IPG_OVERLAP_CLKS != 0);
	assign fifo_pop = (state_reg == SBT_ST_SEND) && fifo_valid;

	// Ring path: bypass forwards bits, arbitration re-emits after decode.
	// Either way the bit crosses the synchroniser and one output flop, four or
	// five clocks in all, well inside the thirty-two clock budget.
	// A package that is not on the ring keeps its output low.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ring_out_reg <= 1'b0;
		end else begin
			if (!hw_arb_i) begin
				ring_out_reg <= 1'b0;
			end else if (bypass_i) begin
				ring_out_reg <= ring_in;
			end else if (state_reg == SBT_ST_WAIT_TOKEN) begin
				ring_out_reg <= 1'b0; // Hold the token while we claim it
			end else begin
				ring_out_reg <= ring_in || (token_req_i && token_early);
			end
		end
	end

	// Power-up, asynchronous and synchronous reset deafness windows.
	// A reset event restarts the count, so back-to-back events stretch the
	// silence; each window still ends within its limit of the last event.
	// While deaf the package starts no transfer of its own.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			deaf_cnt_reg <= CNT_ZERO;
			ready_reg <= 1'b0;
		end else if (async_reset_evt_i || reset_resp_done_i) begin
			deaf_cnt_reg <= CNT_ZERO;
			ready_reg <= 1'b0;
		end else if (!ready_reg) begin
			// Shortest of the windows bounds how long we stay deaf
			if (deaf_cnt_reg >= CNT_W'(POWER_CYC - 1) ||
				deaf_cnt_reg >= CNT_W'(ARST_LIM_CYC - 1) ||
				deaf_cnt_reg >= CNT_W'(SRST_LIM_CYC - 1)) begin
				ready_reg <= 1'b1;
			end else begin
				deaf_cnt_reg <= deaf_cnt_reg + CNT_ONE;
			end
		end
	end

	// Response deadline watchdog.
	// Counting starts at the edge after the last command bit and stops at the
	// first response bit; a late flag stays up until the next command or answer.
	// A response and a new command in the same edge: the response wins.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			exec_cnt_reg <= CNT_ZERO;
			exec_run_reg <= 1'b0;
			late_reg <= 1'b0;
		end else if (resp_start_i) begin
			exec_run_reg <= 1'b0;
			late_reg <= 1'b0;
		end else if (cmd_done_i) begin
			exec_cnt_reg <= CNT_ZERO;
			exec_run_reg <= 1'b1;
			late_reg <= 1'b0;
		end else if (exec_run_reg) begin
			if (exec_cnt_reg >= CNT_W'(EXEC_LIM_CYC - 1)) begin
				late_reg <= 1'b1;
				exec_run_reg <= 1'b0;
			end else begin
				exec_cnt_reg <= exec_cnt_reg + CNT_ONE;
			end
		end
	end

	// Pause renewal window.
	// The window opens with the first pause request; once it has run out,
	// renewals are refused until the request has been dropped for a clock.
	// The allow flag is high whenever no pause condition is open, except in the clock after one closes.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pause_cnt_reg <= CNT_ZERO;
			pause_run_reg <= 1'b0;
			pause_ok_reg <= 1'b1;
		end else if (pause_req_i && !pause_run_reg) begin
			pause_cnt_reg <= CNT_ZERO;
			pause_run_reg <= 1'b1;
			pause_ok_reg <= 1'b1;
		end else if (pause_run_reg) begin
			if (pause_cnt_reg >= CNT_W'(PAUSE_LIM - 1)) begin
				pause_ok_reg <= 1'b0;
				pause_run_reg <= pause_req_i;
			end else begin
				pause_cnt_reg <= pause_cnt_reg + CNT_ONE;
			end
		end else begin
			pause_ok_reg <= 1'b1;
		end
	end

	// Transmit state machine: token, warm-up, send, drain.
	// A transfer starts only when selected, ready and holding data. With ring
	// arbitration on it first waits for the token and gives up after the
	// timeout; the failed attempt repeats at once while data is still held.
	// Warm-up keeps the lanes driven but idle before the first dibit.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_reg <= SBT_ST_QUIET;
			tok_cnt_reg <= CNT_ZERO;
			warm_cnt_reg <= CNT_ZERO;
			tmo_reg <= 1'b0;
		end else begin
			case (state_reg)
				SBT_ST_QUIET: begin
					if (select_i && fifo_valid && ready_reg) begin
						tok_cnt_reg <= CNT_ZERO;
						tmo_reg <= 1'b0;
						state_reg <= hw_arb_i ? SBT_ST_WAIT_TOKEN : SBT_ST_WARMUP;
					end
				end
				SBT_ST_WAIT_TOKEN: begin
					if (!select_i) begin
						state_reg <= SBT_ST_QUIET;
					end else if (token_seen) begin
						warm_cnt_reg <= CNT_ZERO;
						state_reg <= SBT_ST_WARMUP;
					end else if (tok_cnt_reg >= CNT_W'(TOKEN_TMO - 1)) begin
						tmo_reg <= 1'b1;
						state_reg <= SBT_ST_QUIET;
					end else begin
						tok_cnt_reg <= tok_cnt_reg + CNT_ONE;
					end
				end
				SBT_ST_WARMUP: begin
					if (warm_cnt_reg >= CNT_W'(WARMUP_CLKS - 1)) begin
						state_reg <= SBT_ST_SEND;
					end else begin
						warm_cnt_reg <= warm_cnt_reg + CNT_ONE;
					end
				end
				SBT_ST_SEND: begin
					if (fifo_pop && fifo_out.last) begin
						state_reg <= SBT_ST_DRAIN;
					end
				end
				SBT_ST_DRAIN: begin
					state_reg <= SBT_ST_QUIET;
				end
				default: begin
					state_reg <= SBT_ST_QUIET;
				end
			endcase
		end
	end

	// Driver enable: floats at power-up, on drops after deselect.
	// A deselect while idle floats the lanes at the next edge; a deselect in
	// mid-packet lets the packet finish unless the float limit is reached.
	// Drivers only come on during warm-up, and only while selected.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			oe_reg <= 1'b0;
			desel_pend_reg <= 1'b0;
			desel_cnt_reg <= CNT_ZERO;
		end else if (deselect_done_i) begin
			desel_pend_reg <= 1'b1;
			desel_cnt_reg <= CNT_ZERO;
		end else if (desel_pend_reg) begin
			if (desel_cnt_reg >= CNT_W'(DESEL_CYC - 1) || state_reg == SBT_ST_QUIET) begin
				oe_reg <= 1'b0;
				desel_pend_reg <= 1'b0;
			end else begin
				desel_cnt_reg <= desel_cnt_reg + CNT_ONE;
			end
		end else if (state_reg == SBT_ST_WARMUP) begin
			oe_reg <= select_i;
		end else if (!select_i && state_reg == SBT_ST_QUIET) begin
			oe_reg <= 1'b0;
		end
	end

	// Lane outputs, idle low while driven, data only in send.
	// Valid is raised for every dibit; the error lane is never used.
	// Carrier is shown only with data, as full duplex needs no more.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rx_reg <= '0;
		end else if (fifo_pop) begin
			rx_reg <= '{rxd: fifo_out.dibit, crs_dv: 1'b1, rx_er: 1'b0};
		end else begin
			rx_reg <= '0;
		end
	end

	// Every output comes straight from a flop
	assign rx_o = rx_reg;
	assign rx_oe_o = oe_reg;
	assign data_ready_o = room_reg;
	assign arbitration_ring_output = ring_out_reg;
	assign ready_o = ready_reg;
	assign resp_late_o = late_reg;
	assign token_timeout_o = tmo_reg;
	assign pause_allowed_o = pause_ok_reg;
endmodule

// [dv/sbt_timing_checker.sv]
// Concurrent timing checks on the sideband timing block ports
`timescale 1ns/10ps
module sbt_timing_checker #(
	parameter longint unsigned DESEL_CYC = 20,
	parameter longint unsigned POWER_CYC = 20,
	parameter longint unsigned EXEC_LIM_CYC = 20,
	parameter longint unsigned ARST_LIM_CYC = 20,
	parameter longint unsigned SRST_LIM_CYC = 20,
	parameter longint unsigned TOKEN_TMO = 20,
	parameter longint unsigned PAUSE_LIM = 20
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic select_i,
	input wire logic deselect_done_i,
	input wire logic cmd_done_i,
	input wire logic resp_start_i,
	input wire logic async_reset_evt_i,
	input wire logic reset_resp_done_i,
	input wire logic hw_arb_i,
	input wire logic bypass_i,
	input wire logic pause_req_i,
	input wire logic arbitration_ring_input,
	input wire logic arbitration_ring_output,
	input wire sbt_pkg::sbt_rx_s rx_o,
	input wire logic rx_oe_o,
	input wire logic ready_o,
	input wire logic resp_late_o,
	input wire logic token_timeout_o,
	input wire logic pause_allowed_o
);
	import sbt_pkg::*;
	// Upper bounds with room for the pin synchroniser
	localparam int D_HI = int'(DESEL_CYC) + 4;
	localparam int P_HI = int'(POWER_CYC) + 6;
	localparam int A_HI = int'(ARST_LIM_CYC) + 6;
	localparam int S_HI = int'(SRST_LIM_CYC) + 6;
	logic [31:0] exec_cnt_reg; // Cycles since last command without answer
	logic [31:0] tok_cnt_reg; // Cycles of quiet ring input under arbitration
	logic [31:0] pause_cnt_reg; // Cycles of held pause request
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// Command answer watch, cleared by the first response bit
	always_ff @(posedge mclk_i) begin
		if (reset_i || resp_start_i) begin
			exec_cnt_reg <= 32'h0;
		end else if (cmd_done_i) begin
			exec_cnt_reg <= 32'h1;
		end else if (exec_cnt_reg != 32'h0 && exec_cnt_reg < 32'hffff) begin
			exec_cnt_reg <= exec_cnt_reg + 32'h1;
		end
	end
	// Token wait length as seen on the ring input
	always_ff @(posedge mclk_i) begin
		if (reset_i || !hw_arb_i || arbitration_ring_input) begin
			tok_cnt_reg <= 32'h0;
		end else begin
			tok_cnt_reg <= tok_cnt_reg + 32'h1;
		end
	end
	// Pause hold length
	always_ff @(posedge mclk_i) begin
		if (reset_i || !pause_req_i) begin
			pause_cnt_reg <= 32'h0;
		end else begin
			pause_cnt_reg <= pause_cnt_reg + 32'h1;
		end
	end
	property p_desel_float;
		deselect_done_i |-> ##[1:D_HI] !rx_oe_o;
	endproperty
	a_desel_float: assert property (p_desel_float) else $error("drivers still on");
	property p_warmup;
		$rose(rx_oe_o) |-> !rx_o.crs_dv ##1 !rx_o.crs_dv;
	endproperty
	a_warmup: assert property (p_warmup) else $error("data before warm-up");
	property p_oe_sel;
		$rose(rx_oe_o) |-> $past(select_i);
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("drive while unselected");
	property p_dv_oe;
		rx_o.crs_dv |-> rx_oe_o;
	endproperty
	a_dv_oe: assert property (p_dv_oe) else $error("valid while floating");
	property p_power_ready;
		$fell(reset_i) |-> ##[1:P_HI] ready_o;
	endproperty
	a_power_ready: assert property (p_power_ready) else $error("late ready");
	property p_exec_late;
		exec_cnt_reg == EXEC_LIM_CYC + 4 |-> resp_late_o;
	endproperty
	a_exec_late: assert property (p_exec_late) else $error("late answer missed");
	property p_arst_ready;
		async_reset_evt_i |-> ##[1:A_HI] ready_o;
	endproperty
	a_arst_ready: assert property (p_arst_ready) else $error("deaf too long");
	property p_srst_ready;
		reset_resp_done_i |-> ##[1:S_HI] ready_o;
	endproperty
	a_srst_ready: assert property (p_srst_ready) else $error("deaf too long");
	property p_tok_early;
		$rose(token_timeout_o) |-> tok_cnt_reg >= TOKEN_TMO;
	endproperty
	a_tok_early: assert property (p_tok_early) else $error("early token timeout");
	property p_bypass;
		bypass_i && hw_arb_i && $rose(arbitration_ring_input) |-> ##[1:32] arbitration_ring_output;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass bit lost");
	property p_pause;
		pause_cnt_reg == PAUSE_LIM + 4 |-> !pause_allowed_o;
	endproperty
	a_pause: assert property (p_pause) else $error("pause renewal too long");
endmodule
bind sbt_timing sbt_timing_checker #(.DESEL_CYC(DESEL_CYC), .POWER_CYC(POWER_CYC),
	.EXEC_LIM_CYC(EXEC_LIM_CYC), .ARST_LIM_CYC(ARST_LIM_CYC), .SRST_LIM_CYC(SRST_LIM_CYC),
	.TOKEN_TMO(TOKEN_TMO), .PAUSE_LIM(PAUSE_LIM)) u_chk (.mclk_i, .reset_i, .select_i,
	.deselect_done_i, .cmd_done_i, .resp_start_i, .async_reset_evt_i, .reset_resp_done_i,
	.hw_arb_i, .bypass_i, .pause_req_i, .arbitration_ring_input, .arbitration_ring_output,
	.rx_o, .rx_oe_o, .ready_o, .resp_late_o, .token_timeout_o, .pause_allowed_o);

// [dv/sbt_mac_peer.sv]
// Far-side model: ring peer sending the token, receiver of data lanes
`timescale 1ns/10ps
module sbt_mac_peer (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic tok_go_i, // Pulse: send a token after a wait
	input wire logic [7:0] tok_wait_i, // Wait before the token, in clocks
	input wire logic bit_i, // Ring bit for bypass traffic
	input wire sbt_pkg::sbt_rx_s rx_i,
	input wire logic rx_oe_i,
	output logic ring_o,
	output logic got_v_o,
	output logic [1:0] got_o
);
	import sbt_pkg::*;
	logic [8:0] tok_cnt_reg; // Counts down wait, then six token clocks
	// Token launcher; one package on a shared ring of up to four
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			tok_cnt_reg <= 9'h0;
		end else if (tok_go_i) begin
			tok_cnt_reg <= {1'b0, tok_wait_i} + 9'h6;
		end else if (tok_cnt_reg != 9'h0) begin
			tok_cnt_reg <= tok_cnt_reg - 9'h1;
		end
	end
	assign ring_o = bit_i | (tok_cnt_reg != 9'h0 && tok_cnt_reg <= 9'h6);
	// Receive only while the lanes are driven; silence is not an error
	assign got_v_o = rx_oe_i & rx_i.crs_dv;
	assign got_o = rx_i.rxd;
endmodule

// [dv/sbt_timing_tb.sv]
// Self-checking bench for the sideband timing block
`timescale 1ns/10ps
module sbt_timing_tb;
	import sbt_pkg::*;
	localparam longint unsigned LIM = 20; // Shortened deadlines
	localparam longint unsigned TMO = 200; // Shortened token timeout
	logic mclk_i = 0, reset_i = 1, select_i = 0, deselect_done_i = 0, cmd_done_i = 0;
	logic resp_start_i = 0, async_reset_evt_i = 0, reset_resp_done_i = 0, hw_arb_i = 0;
	logic bypass_i = 0, token_req_i = 0, ipg_left_i = 0, pause_req_i = 0, data_valid_i = 0;
	logic data_last_i = 0, tok_go = 0, ring_bit = 0, ring_in, ring_out, data_ready_o;
	logic rx_oe_o, ready_o, resp_late_o, token_timeout_o, pause_allowed_o, got_v;
	logic [1:0] data_i = 0, got, v;
	logic [7:0] tok_wait = 0;
	logic [31:0] seed = 32'h54498374;
	logic [1:0] exp_q[$]; // Dibits expected on the lanes
	sbt_rx_s rx_o;
	int n_fail = 0, checks_done = 0, i, k;
	sbt_timing #(.DESEL_CYC(LIM), .POWER_CYC(LIM), .EXEC_LIM_CYC(LIM), .ARST_LIM_CYC(LIM),
		.SRST_LIM_CYC(LIM), .TOKEN_TMO(TMO), .PAUSE_LIM(LIM)) i_dut (.mclk_i, .reset_i,
		.select_i, .deselect_done_i, .cmd_done_i, .resp_start_i, .async_reset_evt_i,
		.reset_resp_done_i, .hw_arb_i, .bypass_i, .token_req_i, .ipg_left_i, .pause_req_i,
		.data_valid_i, .data_i, .data_last_i, .data_ready_o,
		.arbitration_ring_input(ring_in), .arbitration_ring_output(ring_out), .rx_o,
		.rx_oe_o, .ready_o, .resp_late_o, .token_timeout_o, .pause_allowed_o);
	sbt_mac_peer i_peer (.mclk_i, .reset_i, .tok_go_i(tok_go), .tok_wait_i(tok_wait),
		.bit_i(ring_bit), .rx_i(rx_o), .rx_oe_i(rx_oe_o), .ring_o(ring_in), .got_v_o(got_v),
		.got_o(got));
	// Clock, 40 ns period
	initial begin
		forever #20 mclk_i = ~mclk_i;
	end
	// Gap hint toggles every clock
	always @(posedge mclk_i) begin
		ipg_left_i <= ~ipg_left_i;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic test_done();
		if (n_fail == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One-clock pulse on the chosen strobe
	task automatic pulse(input int s);
		@(posedge mclk_i);
		case (s)
			0: cmd_done_i <= 1;
			1: resp_start_i <= 1;
			2: deselect_done_i <= 1;
			3: async_reset_evt_i <= 1;
			4: reset_resp_done_i <= 1;
			default: tok_go <= 1;
		endcase
		@(posedge mclk_i);
		{cmd_done_i, resp_start_i, deselect_done_i} <= 3'h0;
		{async_reset_evt_i, reset_resp_done_i, tok_go} <= 3'h0;
	endtask
	// Offer one word, note it once taken; valid stays up for the caller
	task automatic push(input logic last);
		v = 2'(rnd());
		data_valid_i <= 1;
		data_i <= v;
		data_last_i <= last;
		for (k = 0; k < 50; k++) begin
			@(posedge mclk_i);
			if (data_ready_o === 1'b1) break;
		end
		exp_q.push_back(v);
	endtask
	task automatic wait_ready();
		for (k = 0; k < 60 && ready_o !== 1'b1; k++) @(posedge mclk_i);
	endtask
	// Lane monitor: each valid dibit against the oldest note
	always @(posedge mclk_i) begin
		if (got_v === 1'b1) begin
			if (exp_q.size() == 0) chk(1, 0);
			else chk(got, exp_q.pop_front());
		end
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_fail++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge mclk_i);
		reset_i <= 0;
		wait_ready();
		chk(ready_o, 1);
		pulse(0);
		repeat (3) @(posedge mclk_i);
		pulse(1);
		repeat (LIM + 6) @(posedge mclk_i);
		chk(resp_late_o, 0);
		pulse(0);
		repeat (LIM + 6) @(posedge mclk_i);
		chk(resp_late_o, 1);
		// Fill the buffer while the token is held back
		select_i <= 1;
		hw_arb_i <= 1;
		token_req_i <= 1;
		for (i = 0; i < 16; i++) push(i == 15);
		data_last_i <= 0;
		@(posedge mclk_i);
		chk(data_ready_o, 0);
		data_valid_i <= 0;
		tok_wait <= 8'(rnd() % 20);
		pulse(5);
		for (i = 0; i < 60 && rx_o.crs_dv !== 1'b1; i++) @(posedge mclk_i);
		chk(rx_o.crs_dv, 1);
		for (i = 0; i < 60 && exp_q.size() != 0; i++) @(posedge mclk_i);
		chk(exp_q.size(), 0);
		pulse(2);
		select_i <= 0;
		repeat (LIM + 6) @(posedge mclk_i);
		chk(rx_oe_o, 0);
		// Bypass: random ring bits forwarded to the ring output
		bypass_i <= 1;
		for (i = 0; i < 8; i++) begin
			ring_bit <= 1'(rnd());
			repeat (12) @(posedge mclk_i);
			chk(ring_out, ring_bit);
		end
		bypass_i <= 0;
		ring_bit <= 0;
		// Arbitration: with the ring quiet, a wanted token leaves only near gap end
		repeat (8) @(posedge mclk_i);
		for (i = 0; i < 6; i++) begin
			v[0] = ipg_left_i;
			@(posedge mclk_i);
			chk(ring_out, v[0]);
		end
		pause_req_i <= 1;
		repeat (LIM + 8) @(posedge mclk_i);
		chk(pause_allowed_o, 0);
		pause_req_i <= 0;
		pulse(3);
		repeat (3) @(posedge mclk_i);
		wait_ready();
		chk(ready_o, 1);
		pulse(4);
		repeat (3) @(posedge mclk_i);
		wait_ready();
		chk(ready_o, 1);
		// Packet with no token ever arriving
		select_i <= 1;
		push(1);
		data_valid_i <= 0;
		exp_q.delete();
		// The flag stands one clock before the next attempt clears it
		for (i = 0; i < TMO + 40 && token_timeout_o !== 1'b1; i++) @(posedge mclk_i);
		chk(token_timeout_o, 1);
		chk(i >= TMO, 1);
		test_done();
	end
endmodule
